// [design/lhsc_pkg.sv]
/*
  shared constants and types for the lock detector halt/restart strobes
  and the soft decision slicer_config.
  assumes a single clock domain and a destination-addressed write port.
*/
`default_nettype none
package lhsc_pkg;
  // ==========================================================
  // register destination addresses
  localparam logic [7:0] LHSC_ADDR_HALT = 8'h18; // halt-for-read strobe
  localparam logic [7:0] LHSC_ADDR_RESTART = 8'h19; // restart strobe
  localparam logic [7:0] LHSC_ADDR_SLICER = 8'h1a; // slicer_config
  // ==========================================================
  // slicer_config fields
  localparam int LHSC_FMT_BIT = 7; // output format select
  localparam int LHSC_THR_MSB = 6; // threshold field top bit
  localparam int LHSC_THR_W = 7; // threshold field width
  localparam logic LHSC_FMT_RESET = 1'h0; // sign/magnitude after reset
  localparam logic [6:0] LHSC_THR_RESET = 7'h00; // threshold after reset
  localparam logic LHSC_FMT_SIGNMAG = 1'h0; // format code: sign/magnitude
  localparam logic LHSC_MODE_PROC = 1'h0; // control code: processor
  // ==========================================================
  // sample and decision widths
  localparam int LHSC_SAMPLE_W = 8; // two's complement fraction
  localparam int LHSC_SOFT_W = 3; // soft decision width
  localparam logic [7:0] LHSC_SAMPLE_MIN = 8'h80; // most negative sample
  localparam logic [6:0] LHSC_MAG_MAX = 7'h7f; // saturated magnitude
  // ==========================================================
  // types
  typedef struct packed {
    logic strobe; // one-cycle write pulse
    logic [7:0] addr; // destination address
    logic [31:0] data; // write data
  } lhsc_wr_type;
  typedef struct packed {
    logic fmt_twos; // 1 = two's complement outputs
    logic [6:0] threshold; // unsigned fraction, msb weighs one half
  } lhsc_slicer_cfg_type;
  typedef enum logic [1:0] {
    LHSC_RUN = 2'b00, // lock detector running freely
    LHSC_PENDING = 2'b01, // halt asked, waiting for cycle end
    LHSC_FROZEN = 2'b10 // frozen, integrators readable
  } lhsc_state_type;
endpackage
`default_nettype wire

// [design/lhsc_slicer.sv]
/*
  soft decision slicer: magnitude against 1x/2x/3x threshold, four levels,
  sign/magnitude or two's complement 3-bit outputs, registered.
  assumes samples arrive on clk_sys with a one-cycle valid.
*/
`default_nettype none
module lhsc_slicer
  import lhsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire lhsc_slicer_cfg_type cfg,
  input wire logic sample_valid,
  input wire logic [LHSC_SAMPLE_W-1:0] i_sample,
  input wire logic [LHSC_SAMPLE_W-1:0] q_sample,
  output logic soft_valid,
  output logic [LHSC_SOFT_W-1:0] i_soft,
  output logic [LHSC_SOFT_W-1:0] q_soft
);
  // ==========================================================
  // magnitude of a two's complement fraction, saturated at the top
  function automatic logic [6:0] lhsc_mag(input logic [7:0] s);
    logic [7:0] neg;
    neg = 8'h00;
    if (s == LHSC_SAMPLE_MIN) begin
      return LHSC_MAG_MAX;
    end
    neg = 8'h00 - s;
    return s[LHSC_SAMPLE_W-1] ? neg[6:0] : s[6:0];
  endfunction

  // confidence level and output coding for one sample
  function automatic logic [2:0] lhsc_decide(input logic [7:0] s, input lhsc_slicer_cfg_type c);
    logic [8:0] mag;
    logic [8:0] t1;
    logic [8:0] t2;
    logic [8:0] t3;
    logic [1:0] lvl;
    mag = {2'h0, lhsc_mag(s)};
    // fraction weights of threshold and magnitude line up bit for bit
    t1 = {2'h0, c.threshold};
    t2 = {1'h0, c.threshold, 1'h0};
    t3 = t1 + t2;
    // level from the highest threshold met or exceeded
    if (mag >= t3) begin
      lvl = 2'h3;
    end else if (mag >= t2) begin
      lvl = 2'h2;
    end else if (mag >= t1) begin
      lvl = 2'h1;
    end else begin
      lvl = 2'h0;
    end
    // format select: sign/magnitude or two's complement
    if (c.fmt_twos == LHSC_FMT_SIGNMAG) begin
      return {s[LHSC_SAMPLE_W-1], lvl};
    end
    return s[LHSC_SAMPLE_W-1] ? ~{1'h0, lvl} : {1'h0, lvl};
  endfunction

  // ==========================================================
  // registered decisions
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      soft_valid <= 1'h0;
      i_soft <= 3'h0;
      q_soft <= 3'h0;
    end else begin
      soft_valid <= sample_valid;
      if (sample_valid) begin
        i_soft <= lhsc_decide(i_sample, cfg);
        q_soft <= lhsc_decide(q_sample, cfg);
      end
    end
  end
endmodule
`default_nettype wire

// [design/lhsc_top.sv]
/*
  lock detector halt/restart strobes and slicer_config register,
  with the slicer instantiated below.
  assumes the write port, integration-done pulse and samples all come from
  logic on clk_sys; the control-mode bit comes from the lock detector
  configuration register held elsewhere.
*/
// How it works
// - halt waits for current integration cycle end
// - status bit 7 shows detector frozen
// - frozen detector stays until restart write
// - restart write resumes frozen detector
// - processor mode: accumulators stop every cycle
// - bit 7 picks sign/magnitude or two's complement
// - thresholds are one, two, three times field
// - threshold is unsigned fraction, msb one half
// - mode bit: 0 processor, 1 state machine
`default_nettype none
module lhsc_top
  import lhsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire lhsc_wr_type wr,
  input wire logic sm_control,
  input wire logic integ_done,
  input wire logic sample_valid,
  input wire logic [LHSC_SAMPLE_W-1:0] i_sample,
  input wire logic [LHSC_SAMPLE_W-1:0] q_sample,
  output logic ld_frozen,
  output logic status_halted,
  output lhsc_slicer_cfg_type slicer_cfg,
  output logic soft_valid,
  output logic [LHSC_SOFT_W-1:0] i_soft,
  output logic [LHSC_SOFT_W-1:0] q_soft
);
  // ==========================================================
  // address decode
  // data is never looked at for the two strobes
  logic halt_wr; // halt strobe written
  logic restart_wr; // restart strobe written
  logic slicer_wr; // slicer config written
  logic proc_mode; // processor owns acquisition
  lhsc_state_type state; // halt sequencer state
  lhsc_state_type next_state; // next sequencer state

  assign halt_wr = wr.strobe && (wr.addr == LHSC_ADDR_HALT);
  assign restart_wr = wr.strobe && (wr.addr == LHSC_ADDR_RESTART);
  assign slicer_wr = wr.strobe && (wr.addr == LHSC_ADDR_SLICER);
  assign proc_mode = (sm_control == LHSC_MODE_PROC);

  // ==========================================================
  // halt sequencer
  // next state from strobes, mode and the integration-done pulse
  always_comb begin
    next_state = state;
    unique case (state)
      LHSC_RUN: begin
        if (proc_mode && integ_done) begin
          // accumulators park by themselves at every cycle end
          next_state = LHSC_FROZEN;
        end else if (!proc_mode && halt_wr) begin
          // strobe is meaningless under processor control
          next_state = LHSC_PENDING;
        end
      end
      LHSC_PENDING: begin
        if (restart_wr) begin
          next_state = LHSC_RUN; // halt withdrawn before it took
        end else if (integ_done) begin
          next_state = LHSC_FROZEN; // cycle finished, now freeze
        end
      end
      LHSC_FROZEN: begin
        // only a restart write leaves
        if (restart_wr) begin
          next_state = LHSC_RUN;
        end
      end
      default: begin
        next_state = LHSC_RUN; // illegal code recovers to run
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= LHSC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // freeze and status outputs, registered with the state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ld_frozen <= 1'h0;
      status_halted <= 1'h0;
    end else begin
      ld_frozen <= (next_state == LHSC_FROZEN);
      status_halted <= (next_state == LHSC_FROZEN); // internal status bit 7
    end
  end

  // ==========================================================
  // slicer_config register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      slicer_cfg.fmt_twos <= LHSC_FMT_RESET;
      slicer_cfg.threshold <= LHSC_THR_RESET;
    end else if (slicer_wr) begin
      slicer_cfg.fmt_twos <= wr.data[LHSC_FMT_BIT];
      slicer_cfg.threshold <= wr.data[LHSC_THR_MSB -: LHSC_THR_W];
    end
  end

  // ==========================================================
  // slicer datapath
  // no clamp on the threshold; software keeps 3x in range
  lhsc_slicer u_slicer (
    .clk_sys(clk_sys),
    .rst(rst),
    .cfg(slicer_cfg),
    .sample_valid(sample_valid),
    .i_sample(i_sample),
    .q_sample(q_sample),
    .soft_valid(soft_valid),
    .i_soft(i_soft),
    .q_soft(q_soft)
  );
endmodule
`default_nettype wire

// [verification/lhsc_top_properties.sv]
/*
  port-level checks of the halt/restart strobes and the slicer register.
  assumes one clock, clk_sys, and a synchronous active-high rst.
*/
`default_nettype none
module lhsc_top_properties
  import lhsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire lhsc_wr_type wr,
  input wire logic sm_control,
  input wire logic integ_done,
  input wire logic sample_valid,
  input wire logic ld_frozen,
  input wire logic status_halted,
  input wire lhsc_slicer_cfg_type slicer_cfg,
  input wire logic soft_valid
);
  // ==========================================================
  // decoded writes
  logic halt_w; // halt strobe this cycle
  logic rest_w; // restart strobe this cycle
  logic cfg_w; // slicer write this cycle
  assign halt_w = wr.strobe && wr.addr == LHSC_ADDR_HALT;
  assign rest_w = wr.strobe && wr.addr == LHSC_ADDR_RESTART;
  assign cfg_w = wr.strobe && wr.addr == LHSC_ADDR_SLICER;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================================
  // assertions
  halt_waits_a: assert property (halt_w && !integ_done && !ld_frozen |=> !ld_frozen) else $error("early freeze");
  freeze_cause_a: assert property ($rose(ld_frozen) |-> $past(integ_done)) else $error("freeze without cycle end");
  status_mirror_a: assert property (status_halted == ld_frozen) else $error("status bit differs");
  frozen_hold_a: assert property (ld_frozen && !rest_w |=> ld_frozen) else $error("freeze lost");
  restart_release_a: assert property (rest_w && !integ_done |=> !ld_frozen) else $error("restart ignored");
  proc_freeze_a: assert property (!sm_control && integ_done && !ld_frozen && !rest_w |=> ld_frozen) else $error("no self stop");
  cfg_load_a: assert property (cfg_w |=> slicer_cfg == $past(wr.data[7:0])) else $error("slicer load wrong");
  cfg_stable_a: assert property (!cfg_w |=> $stable(slicer_cfg)) else $error("slicer changed");
  // soft_valid follows sample_valid by exactly one cycle, back to back too
  soft_latency_a: assert property (sample_valid |=> soft_valid ##1 (soft_valid == $past(sample_valid))) else $error("soft valid late");
  // ==========================================================
  // covers
  halt_seen_c: cover property (halt_w ##[1:20] ld_frozen);
  proc_stop_c: cover property (!sm_control && integ_done);
  twos_out_c: cover property (soft_valid && slicer_cfg.fmt_twos);
endmodule
bind lhsc_top lhsc_top_properties u_props (.clk_sys(clk_sys), .rst(rst), .wr(wr), .sm_control(sm_control),
  .integ_done(integ_done), .sample_valid(sample_valid), .ld_frozen(ld_frozen), .status_halted(status_halted),
  .slicer_cfg(slicer_cfg), .soft_valid(soft_valid));
`default_nettype wire

// [verification/tb_lhsc_top.sv]
/*
  self-checking bench: random and corner slicer traffic, halt/restart runs.
  assumes lhsc_pkg and the design are compiled first.
*/
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb_lhsc_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lhsc_pkg::*;
  logic clk_sys, rst, sm_control, integ_done, sample_valid, ld_frozen, status_halted, soft_valid;
  lhsc_wr_type wr;
  lhsc_slicer_cfg_type slicer_cfg;
  logic [7:0] i_sample, q_sample, cfg;
  logic [2:0] i_soft, q_soft;
  logic [31:0] d;
  int error_cnt = 0;
  int tests_run = 0;
  lhsc_top u_dut (.clk_sys(clk_sys), .rst(rst), .wr(wr), .sm_control(sm_control), .integ_done(integ_done),
    .sample_valid(sample_valid), .i_sample(i_sample), .q_sample(q_sample), .ld_frozen(ld_frozen),
    .status_halted(status_halted), .slicer_cfg(slicer_cfg), .soft_valid(soft_valid), .i_soft(i_soft), .q_soft(q_soft));
  // ==========================================================
  // expected soft decision from sample and slicer setting
  function automatic logic [2:0] exp_soft(input logic [7:0] s, input logic [7:0] c);
    int m, t, l;
    m = s[7] ? 256 - s : s;
    if (m > 127) m = 127;
    t = c[6:0];
    l = (m >= 3 * t) ? 3 : (m >= 2 * t) ? 2 : (m >= t) ? 1 : 0;
    if (c[7] && s[7]) return ~{1'b0, l[1:0]};
    return {s[7] && !c[7], l[1:0]};
  endfunction
  // ==========================================================
  // drivers, one idle cycle after each pulse
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    wr = '{1'b1, a, v};
    step();
    wr.strobe = 1'b0;
    step();
  endtask
  task automatic integ();
    integ_done = 1'b1;
    step();
    integ_done = 1'b0;
    step();
  endtask
  task automatic chk_fz(input logic e);
    `CHK("ld_frozen", e, ld_frozen)
    `CHK("status_halted", e, status_halted)
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // hang guard
  initial begin
    #1ms;
    error_cnt++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    wr = '0;
    sm_control = 1'b1;
    integ_done = 1'b0;
    sample_valid = 1'b0;
    i_sample = 8'h00;
    q_sample = 8'h00;
    void'($urandom(32'hf604));
    step(4);
    rst = 1'b0;
    `CHK("slicer_cfg", 8'h00, slicer_cfg)
    chk_fz(1'b0);
    // slicer traffic with corner settings and samples
    for (int k = 0; k < 48; k++) begin
      if (k % 8 == 0) begin
        d = $urandom;
        // keep the threshold at or below one third of full scale
        d[6:0] = 7'(d[6:0] % 43);
        if (k < 16) d[7:0] = (k == 0) ? 8'h00 : 8'h85;
        cfg = d[7:0];
        wr_reg(LHSC_ADDR_SLICER, d);
        `CHK("slicer_cfg", cfg, slicer_cfg)
        wr_reg(8'h1b, ~d);
        `CHK("slicer_cfg", cfg, slicer_cfg)
      end
      i_sample = (k % 8 == 1) ? 8'h80 : 8'($urandom);
      q_sample = (k % 8 == 2) ? 8'h7f : 8'($urandom);
      sample_valid = 1'b1;
      step();
      sample_valid = 1'b0;
      `CHK("soft_valid", 1'b1, soft_valid)
      `CHK("i_soft", exp_soft(i_sample, cfg), i_soft)
      `CHK("q_soft", exp_soft(q_sample, cfg), q_soft)
      step();
    end
    // halt together with a cycle end must wait for the next one
    // halt strobes only while the state machine owns lock detection
    wr = '{1'b1, LHSC_ADDR_HALT, d};
    integ_done = 1'b1;
    step();
    wr.strobe = 1'b0;
    integ_done = 1'b0;
    step(3);
    chk_fz(1'b0);
    integ();
    chk_fz(1'b1);
    integ();
    wr_reg(LHSC_ADDR_HALT, ~d);
    step(5);
    chk_fz(1'b1);
    wr_reg(LHSC_ADDR_RESTART, d);
    chk_fz(1'b0);
    // restart while pending cancels the halt
    wr_reg(LHSC_ADDR_HALT, 32'h0);
    wr_reg(LHSC_ADDR_RESTART, 32'hffffffff);
    integ();
    chk_fz(1'b0);
    // processor mode stops on every cycle end
    sm_control = 1'b0;
    integ();
    chk_fz(1'b1);
    wr_reg(LHSC_ADDR_RESTART, d);
    chk_fz(1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
